// ==== bench/seb_bank_tb.sv ====
// self-checking bench for the socket event bank
module seb_bank_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [31:0] B = 32'h4000_0000;
	logic        clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0;
	logic [7:0]  cfg_addr = 8'h14;
	logic [19:0] exp_base = 20'h0;
	logic        is32 = 1'b1, crst = 1'b0, ien = 1'b0, ilvl = 1'b1;
	logic [3:0]  st = 4'h0, o;
	logic        valid, write, hit, ready, irq, ok;
	logic [31:0] addr, wdata, rdata, r, seed = 32'h2e1e;
	int          num_errors = 0, cmp_count = 0, cyc = 0;

	seb_bank seb_bank_inst (.CLK(clk), .RST(rst), .CFG_WR(cfg_wr), .CFG_ADDR(cfg_addr),
		.CFG_WDATA(B), .MEM_VALID(valid), .MEM_WRITE(write), .MEM_ADDR(addr),
		.MEM_BE(4'hf), .MEM_WDATA(wdata), .MEM_HIT(hit), .MEM_READY(ready),
		.MEM_RDATA(rdata), .POWER_CYCLE_STATE(st[3]), .CARD_DETECT_TWO_STATE(st[2]),
		.CARD_DETECT_ONE_STATE(st[1]), .CARD_STATUS_STATE(st[0]), .CARD_IS_32BIT(is32),
		.CARD_RESET(crst), .INT_ENABLE(ien), .INT_LEVEL_MODE(ilvl),
		.STATUS_CHANGE_INT(irq));
	seb_host_model seb_host_model_inst (.clk(clk), .valid(valid), .write(write),
		.addr(addr), .wdata(wdata), .ready(ready), .rdata(rdata));

	initial forever #5 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			conclude();
		end
	end

	// every request must hit exactly when its page matches the loaded base
	always @(posedge clk) begin
		if (valid) begin
			check({31'h0, hit}, {31'h0, addr[31:12] == exp_base});
		end
	end

	task automatic conclude();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input logic [31:0] a, d);
		seb_host_model_inst.cycle(1'b1, a, d, r, ok);
	endtask

	task automatic ex(input logic [31:0] a, exp);
		logic [31:0] d;
		logic        k;
		seb_host_model_inst.cycle(1'b0, a, 32'h0, d, k);
		check({31'h0, k}, 32'h1);
		check(d, exp);
	endtask

	// a 32-bit card flags the status bit only when it rises
	function automatic logic [3:0] exp_ev(logic [3:0] p, n, logic c32);
		exp_ev = (p ^ n) & {3'b111, ~c32 | n[0]};
	endfunction

	initial begin
		tick(12);
		rst = 1'b0;
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		seb_host_model_inst.cycle(1'b0, B, 32'h0, r, ok);
		check({31'h0, ok}, 32'h0);
		cfg_addr = 8'h10;
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		exp_base = B[31:12];
		ex(B, 32'h0);
		ex(B + 32'h8, 32'h3000_0000);
		for (int a = 'h10; a <= 'h20; a += 4) begin
			ex(B + a, 32'h0);
		end
		seb_host_model_inst.cycle(1'b0, 32'h5000_0000, 32'h0, r, ok);
		check({31'h0, ok}, 32'h0);
		wr(B + 32'hc, 32'hf);
		ex(B, 32'hf);
		wr(B, 32'hffff_fff0);
		ex(B, 32'hf);
		wr(B, 32'h5);
		ex(B, 32'ha);
		wr(B, 32'ha);
		ex(B, 32'h0);
		wr(B + 32'h4, 32'hffff_ffff);
		ex(B + 32'h4, 32'hf);
		wr(B + 32'h4, 32'h2);
		ien = 1'b1;
		wr(B + 32'hc, 32'h2);
		tick(3);
		check({31'h0, irq}, 32'h0);
		wr(B + 32'h4, 32'h6);
		tick(7);
		check({31'h0, irq}, 32'h1);
		wr(B, 32'h2);
		tick(3);
		check({31'h0, irq}, 32'h0);
		ilvl = 1'b0;
		wr(B + 32'hc, 32'h2);
		tick(1);
		check({31'h0, irq}, 32'h1);
		tick(1);
		check({31'h0, irq}, 32'h0);
		wr(B, 32'h2);
		ilvl = 1'b1;
		ien = 1'b0;
		for (int i = 0; i < 40; i++) begin
			o = st;
			r = $random(seed);
			is32 = r[0];
			st = st ^ (4'h1 << r[2:1]);
			tick(3);
			ex(B + 32'h8, 32'h3000_0000 | st);
			ex(B, {28'h0, exp_ev(o, st, is32)});
			wr(B, 32'hf);
		end
		st = 4'h2;
		tick(3);
		wr(B, 32'hf);
		crst = 1'b1;
		tick(2);
		crst = 1'b0;
		tick(3);
		ex(B, 32'h2);
		wr(B + 32'hc, 32'hf);
		rst = 1'b1;
		exp_base = 20'h0;
		tick(2);
		rst = 1'b0;
		tick(1);
		ex(32'h0, 32'h0);
		conclude();
	end
endmodule // seb_bank_tb

// ==== bench/seb_host_model.sv ====
// host bus model issuing single memory cycles to the socket bank
module seb_host_model (
	// bus clock
	input  wire logic        clk,
	// memory cycle request
	output logic             valid,
	output logic             write,
	output logic [31:0]      addr,
	output logic [31:0]      wdata,
	// answer
	input  wire logic        ready,
	input  wire logic [31:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		valid = 1'b0;
		write = 1'b0;
		addr  = 32'hffff_ffff;
		wdata = 32'h0;
	end

	// request held for the taking edge; address and data scrambled once released
	task automatic cycle(input logic w, input logic [31:0] a, d, output logic [31:0] r,
		output logic ok);
		@(negedge clk);
		valid = 1'b1;
		write = w;
		addr  = a;
		wdata = d;
		@(negedge clk);
		valid = 1'b0;
		addr  = ~a;
		wdata = ~d;
		ok    = ready;
		r     = rdata;
	endtask
endmodule // seb_host_model

// ==== logic/seb_bank.sv ====
// socket register bank with the socket event register, reached by memory cycles
// Operation
// - five socket registers plus power management
// - fixed map from event 00h to 20h
// - bank decoded at configured memory base
// - flags record change, not new state
// - write one clears flag, zero keeps
// - force write one sets matching flag
// - reset clears every event flag
// - leaving card reset may re-set flags
// - unmasked set flag raises status interrupt
// - event bits 31..4 read zero
// - power-cycle state change sets bit 3
// - second detect change sets bit 2
// - first detect change sets bit 1
// - 32-bit card: rising status sets bit 0
// - 16-bit card: both status edges set bit 0
// - detect mask enables only at 11
`include "seb_params.svh"

module seb_bank
	import seb_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// configuration write of the base address
	input  wire logic        CFG_WR,
	input  wire logic [7:0]  CFG_ADDR,
	input  wire logic [31:0] CFG_WDATA,
	// memory cycles
	input  wire logic        MEM_VALID,
	input  wire logic        MEM_WRITE,
	input  wire logic [31:0] MEM_ADDR,
	input  wire logic [3:0]  MEM_BE,
	input  wire logic [31:0] MEM_WDATA,
	output logic             MEM_HIT,
	output logic             MEM_READY,
	output logic [31:0]      MEM_RDATA,
	// socket state
	input  wire logic        POWER_CYCLE_STATE,
	input  wire logic        CARD_DETECT_TWO_STATE,
	input  wire logic        CARD_DETECT_ONE_STATE,
	input  wire logic        CARD_STATUS_STATE,
	input  wire logic        CARD_IS_32BIT,
	input  wire logic        CARD_RESET,
	// interrupt
	input  wire logic        INT_ENABLE,
	input  wire logic        INT_LEVEL_MODE,
	output logic             STATUS_CHANGE_INT
);

	logic [19:0]   base_reg;
	seb_flags_type event_reg;
	seb_flags_type event_next;
	seb_flags_type mask_reg;
	seb_flags_type eff_mask;
	seb_flags_type state;
	seb_flags_type change;
	seb_flags_type clear_vec;
	seb_flags_type force_vec;
	seb_flags_type release_vec;
	seb_flags_type set_vec;
	logic          card_reset_reg;
	logic          pending;
	logic          pending_reg;
	logic          int_reg;
	logic          ready_reg;
	logic [31:0]   rdata_reg;
	logic          hit;
	logic          wr_low;
	seb_sel_type   sel;

	// offset within the window to register select
	function automatic seb_sel_type decode(input logic [11:0] off);
		case (off)
			`SEB_OFF_EVENT:      decode = SEB_SEL_EVENT;
			`SEB_OFF_MASK:       decode = SEB_SEL_MASK;
			`SEB_OFF_PRESENT:    decode = SEB_SEL_PRESENT;
			`SEB_OFF_FORCE:      decode = SEB_SEL_FORCE;
			`SEB_OFF_CONTROL:    decode = SEB_SEL_CONTROL;
			`SEB_OFF_POWER_MGMT: decode = SEB_SEL_POWER;
			default:             decode = SEB_SEL_NONE;
		endcase
	endfunction

	assign state = {POWER_CYCLE_STATE, CARD_DETECT_TWO_STATE,
		CARD_DETECT_ONE_STATE, CARD_STATUS_STATE};

	// base address from configuration space, 4 KB window
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			base_reg <= `SEB_BASE_RESET;
		end else if (CFG_WR && CFG_ADDR == `SEB_CFG_BASE_OFFSET) begin
			base_reg <= CFG_WDATA[31:12];
		end
	end

	assign hit     = MEM_VALID && (MEM_ADDR[31:12] == base_reg);
	assign MEM_HIT = hit;
	assign sel     = decode(MEM_ADDR[11:0]);
	assign wr_low  = hit && MEM_WRITE && MEM_BE[0];

	seb_change_detect u_detect (
		.clk      (CLK),
		.rst      (RST),
		.state    (state),
		.is_32bit (CARD_IS_32BIT),
		.change   (change)
	);

	// leaving card reset re-arms the status and detect flags whose state still stands
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			card_reset_reg <= 1'b0;
		end else begin
			card_reset_reg <= CARD_RESET;
		end
	end

	always_comb begin
		release_vec = 4'h0;
		if (card_reset_reg && !CARD_RESET) begin
			release_vec[`SEB_BIT_STATUS]     = CARD_STATUS_STATE;
			release_vec[`SEB_BIT_DETECT_ONE] = CARD_DETECT_ONE_STATE;
			release_vec[`SEB_BIT_DETECT_TWO] = CARD_DETECT_TWO_STATE;
		end
	end

	assign clear_vec = (wr_low && sel == SEB_SEL_EVENT) ? MEM_WDATA[3:0] : 4'h0;
	assign force_vec = (wr_low && sel == SEB_SEL_FORCE) ? MEM_WDATA[3:0] : 4'h0;
	assign set_vec   = change | force_vec | release_vec;
	// a set in the same cycle as a clear keeps the flag
	assign event_next = (event_reg & ~clear_vec) | set_vec;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			event_reg <= `SEB_EVENT_RESET;
		end else begin
			event_reg <= event_next;
		end
	end

	// mask register, low four bits writable
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			mask_reg <= `SEB_MASK_RESET;
		end else if (wr_low && sel == SEB_SEL_MASK) begin
			mask_reg <= MEM_WDATA[3:0];
		end
	end

	// detect mask only counts when both bits are set
	always_comb begin
		eff_mask = mask_reg;
		eff_mask[2:1] = (mask_reg[2:1] == `SEB_DETECT_MASK_ON) ? 2'h3 : 2'h0;
	end

	assign pending = |(event_reg & eff_mask);

	// level mode follows pending; edge mode pulses on a new pending
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pending_reg <= 1'b0;
			int_reg     <= 1'b0;
		end else begin
			pending_reg <= pending;
			if (!INT_ENABLE) begin
				int_reg <= 1'b0;
			end else if (INT_LEVEL_MODE) begin
				int_reg <= pending;
			end else begin
				int_reg <= pending && !pending_reg;
			end
		end
	end

	assign STATUS_CHANGE_INT = int_reg;

	// read data and completion one cycle after the request
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ready_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ready_reg <= hit;
			rdata_reg <= 32'h0000_0000;
			if (hit && !MEM_WRITE) begin
				case (sel)
					SEB_SEL_EVENT:   rdata_reg <= {28'h0000000, event_reg};
					SEB_SEL_MASK:    rdata_reg <= {28'h0000000, mask_reg};
					SEB_SEL_PRESENT: rdata_reg <= `SEB_PRESENT_FIXED | {28'h0000000, state};
					default:         rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign MEM_READY = ready_reg;
	assign MEM_RDATA = rdata_reg;

	// checks

	a_reserved_zero: assert property (
		@(posedge CLK) disable iff (RST)
		hit && !MEM_WRITE && sel == SEB_SEL_EVENT |=> MEM_READY && MEM_RDATA[31:4] == 28'h0)
		else $error("reserved event bits read nonzero");

	a_write_one_clears: assert property (
		@(posedge CLK) disable iff (RST)
		wr_low && sel == SEB_SEL_EVENT && MEM_WDATA[0] && set_vec[0] == 1'b0
		|=> event_reg[0] == 1'b0)
		else $error("write one did not clear flag");

	a_write_zero_keeps: assert property (
		@(posedge CLK) disable iff (RST)
		wr_low && sel == SEB_SEL_EVENT && !MEM_WDATA[3] && event_reg[3]
		|=> event_reg[3])
		else $error("write zero cleared flag");

	a_force_sets: assert property (
		@(posedge CLK) disable iff (RST)
		wr_low && sel == SEB_SEL_FORCE && MEM_WDATA[2] |=> event_reg[2])
		else $error("force did not set flag");

	a_reset_clears: assert property (
		@(posedge CLK)
		RST |=> event_reg == 4'h0)
		else $error("flags not clear in reset");

	a_power_change: assert property (
		@(posedge CLK) disable iff (RST)
		!$past(RST, 2) && POWER_CYCLE_STATE != $past(POWER_CYCLE_STATE)
		|=> event_reg[3])
		else $error("power change missed");

	a_detect_two: assert property (
		@(posedge CLK) disable iff (RST)
		!$past(RST, 2) && $changed(CARD_DETECT_TWO_STATE) |=> event_reg[2])
		else $error("detect two change missed");

	a_detect_one: assert property (
		@(posedge CLK) disable iff (RST)
		!$past(RST, 2) && $changed(CARD_DETECT_ONE_STATE) |=> event_reg[1])
		else $error("detect one change missed");

	a_rise_32bit: assert property (
		@(posedge CLK) disable iff (RST)
		!$past(RST, 2) && CARD_IS_32BIT && $rose(CARD_STATUS_STATE) |=> event_reg[0])
		else $error("rising status missed");

	a_fall_32_quiet: assert property (
		@(posedge CLK) disable iff (RST)
		CARD_IS_32BIT && $fell(CARD_STATUS_STATE) && !event_reg[0]
		&& !force_vec[0] && !release_vec[0] |=> !event_reg[0])
		else $error("falling status set flag on 32-bit card");

	a_fall_16bit: assert property (
		@(posedge CLK) disable iff (RST)
		!$past(RST, 2) && !CARD_IS_32BIT && $fell(CARD_STATUS_STATE) |=> event_reg[0])
		else $error("falling status missed on 16-bit card");

	a_detect_mask_half: assert property (
		@(posedge CLK) disable iff (RST)
		INT_ENABLE && INT_LEVEL_MODE && mask_reg == 4'h2 && event_reg != 4'h0
		|=> !STATUS_CHANGE_INT)
		else $error("reserved detect mask raised interrupt");

	a_level_holds: assert property (
		@(posedge CLK) disable iff (RST)
		INT_ENABLE && INT_LEVEL_MODE && |(event_reg & eff_mask)
		|=> STATUS_CHANGE_INT)
		else $error("level interrupt not held");

	a_irq_quiet: assert property (
		@(posedge CLK) disable iff (RST)
		(event_reg & eff_mask) == 4'h0 |=> !STATUS_CHANGE_INT)
		else $error("interrupt without unmasked flag");

	a_edge_single: assert property (
		@(posedge CLK) disable iff (RST)
		!INT_LEVEL_MODE && STATUS_CHANGE_INT |=> !STATUS_CHANGE_INT)
		else $error("edge interrupt longer than one cycle");

	a_edge_pulse: assert property (
		@(posedge CLK) disable iff (RST)
		INT_ENABLE && !INT_LEVEL_MODE && pending && !$past(pending)
		|=> STATUS_CHANGE_INT)
		else $error("edge interrupt missed");

	a_miss_quiet: assert property (
		@(posedge CLK) disable iff (RST)
		!hit |=> !MEM_READY && MEM_RDATA == 32'h0000_0000)
		else $error("answer without a hit");

	a_hit_answers: assert property (
		@(posedge CLK) disable iff (RST)
		hit |=> MEM_READY)
		else $error("hit without ready");

	a_base_load: assert property (
		@(posedge CLK) disable iff (RST)
		CFG_WR && CFG_ADDR == `SEB_CFG_BASE_OFFSET |=> base_reg == $past(CFG_WDATA[31:12]))
		else $error("base address not loaded");

	a_card_rearm: assert property (
		@(posedge CLK) disable iff (RST)
		!$past(RST) && $fell(CARD_RESET)
		|=> (event_reg[2:0] & $past(state[2:0])) == $past(state[2:0]))
		else $error("flag not re-set on leaving card reset");

endmodule // seb_bank

// ==== logic/seb_change_detect.sv ====
// change detection on the four socket state bits
`include "seb_params.svh"

module seb_change_detect
	import seb_pkg::*;
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// state
	input  wire seb_flags_type state,
	input  wire logic          is_32bit,
	// change pulses, one per flag bit
	output seb_flags_type      change
);

	seb_flags_type prev_reg;
	logic          armed_reg;
	seb_flags_type diff;

	// previous value of each state bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_reg  <= 4'h0;
			armed_reg <= 1'b0;
		end else begin
			prev_reg  <= state;
			armed_reg <= 1'b1;
		end
	end

	// compare against last cycle; nothing until a first sample exists
	always_comb begin
		diff = armed_reg ? (state ^ prev_reg) : 4'h0;
		change = diff;
		// 32-bit cards count only rising status edges, 16-bit cards both
		if (is_32bit) begin
			change[`SEB_BIT_STATUS] = diff[`SEB_BIT_STATUS] & state[`SEB_BIT_STATUS];
		end else begin
			change[`SEB_BIT_STATUS] = diff[`SEB_BIT_STATUS];
		end
	end

endmodule // seb_change_detect

// ==== logic/seb_params.svh ====
// offsets, field positions, reset values and timing counts for the socket event bank
`ifndef SEB_PARAMS_SVH
`define SEB_PARAMS_SVH

`define SEB_CFG_BASE_OFFSET   8'h10
`define SEB_OFF_EVENT         12'h000
`define SEB_OFF_MASK          12'h004
`define SEB_OFF_PRESENT       12'h008
`define SEB_OFF_FORCE         12'h00c
`define SEB_OFF_CONTROL       12'h010
`define SEB_OFF_RSVD_LO       12'h014
`define SEB_OFF_RSVD_HI       12'h01c
`define SEB_OFF_POWER_MGMT    12'h020

`define SEB_BIT_POWER         3
`define SEB_BIT_DETECT_TWO    2
`define SEB_BIT_DETECT_ONE    1
`define SEB_BIT_STATUS        0
`define SEB_FLAG_WIDTH        4

`define SEB_EVENT_RESET       4'h0
`define SEB_MASK_RESET        4'h0
`define SEB_PRESENT_FIXED     32'h3000_0000
`define SEB_BASE_RESET        20'h00000
`define SEB_DETECT_MASK_ON    2'h3

`define SEB_ACCESS_LATENCY    1

`endif

// ==== logic/seb_pkg.sv ====
// types shared by the socket event bank
package seb_pkg;

	typedef enum logic [2:0] {
		SEB_SEL_EVENT   = 3'b000,
		SEB_SEL_MASK    = 3'b001,
		SEB_SEL_PRESENT = 3'b010,
		SEB_SEL_FORCE   = 3'b011,
		SEB_SEL_CONTROL = 3'b100,
		SEB_SEL_POWER   = 3'b101,
		SEB_SEL_NONE    = 3'b110
	} seb_sel_type;

	typedef logic [3:0] seb_flags_type;

endpackage : seb_pkg
